// ### src/sblu_device.sv
// Bootloader device end: strap entry, menu, XModem-CRC receive with error codes.
// Assumes the host keeps its strap and break sequence; image content checks
// (header, tags, flash) are reported from the image status inputs.
`timescale 1ns/1ns
module sblu_device
  import sblu_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = TIMEOUT_CYC_DEF,
  parameter int unsigned GAP_CYC = GAP_CYC_DEF
)
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Link
  sblu_if.device link,
  // Image store status
  input wire logic app_valid_in,
  input wire logic [7:0] image_err_in,
  // User side
  output logic bl_active_out,
  output logic blk_valid_out,
  output logic [7:0] blk_byte_out,
  output logic [7:0] err_code_out
);
  typedef enum {S_STRAP, S_APP, S_WAIT_CR, S_MENU, S_IDLE, S_POLL, S_SOH, S_SEQ, S_NSEQ,
    S_DATA, S_CRCH, S_CRCL, S_REPLY} sblu_dst_t;
  sblu_dst_t st_q;
  logic [1:0] din_s_q;
  logic [1:0] slp_s_q;
  logic [1:0] rts_s_q;
  logic [1:0] rst_s_q;
  logic [31:0] tmr_q;
  logic [31:0] gap_q;
  logic [7:0] seq_q;
  logic [7:0] exp_q;
  logic [7:0] idx_q;
  logic [15:0] crc_q;
  logic [7:0] crch_q;
  logic [7:0] reply_q;
  logic [2:0] menu_q;
  logic [7:0] err_q;
  logic go_q;
  logic [7:0] txd_q;
  logic dout_q;
  logic rxv;
  logic [7:0] rxd;
  logic txb;
  logic txw;
  logic [15:0] crc_nx;
  logic timed_out;
  logic gap_hit;

  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ 16'h1021) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] menu_chr(input logic [2:0] i);
    case (i)
      3'h0: return CH_CR;
      3'h1: return CH_B;
      3'h2: return CH_L;
      3'h3: return CH_SP;
      default: return CH_GT;
    endcase
  endfunction

  sblu_uart u_uart (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .rx_in(din_s_q[1]),
    .tx_out(txw),
    .tx_go_in(go_q),
    .tx_data_in(txd_q),
    .tx_busy_out(txb),
    .rx_valid_out(rxv),
    .rx_data_out(rxd)
  );

  assign crc_nx = crc16(crc_q, rxd);
  assign timed_out = (tmr_q >= TIMEOUT_CYC - 1);
  assign gap_hit = (gap_q >= GAP_CYC - 1);
  assign link.dout = dout_q;
  // Flow control is never used: rts_n only serves as a strap

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      din_s_q <= 2'b11;
      slp_s_q <= 2'b11;
      rts_s_q <= 2'b00;
      rst_s_q <= 2'b00;
      dout_q <= 1'b1;
    end else begin
      din_s_q <= {din_s_q[0], link.din};
      slp_s_q <= {slp_s_q[0], link.sleep_request_input};
      rts_s_q <= {rts_s_q[0], link.rts_n};
      rst_s_q <= {rst_s_q[0], link.dev_rst_n};
      dout_q <= txw;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= S_STRAP;
      tmr_q <= 32'h0;
      gap_q <= 32'h0;
      seq_q <= 8'h00;
      exp_q <= 8'h01;
      idx_q <= 8'h00;
      crc_q <= 16'h0000;
      crch_q <= 8'h00;
      reply_q <= 8'h00;
      menu_q <= 3'h0;
      err_q <= E_NONE;
      go_q <= 1'b0;
      txd_q <= 8'h00;
      blk_valid_out <= 1'b0;
      blk_byte_out <= 8'h00;
      err_code_out <= E_NONE;
      bl_active_out <= 1'b0;
    end else if (!rst_s_q[1]) begin
      // Device reset from the link restarts the strap check; a cut upload is lost
      st_q <= S_STRAP;
      go_q <= 1'b0;
      blk_valid_out <= 1'b0;
      bl_active_out <= 1'b0;
    end else begin
      go_q <= 1'b0;
      blk_valid_out <= 1'b0;
      tmr_q <= tmr_q + 32'h1;
      gap_q <= rxv ? 32'h0 : gap_q + 32'h1;
      case (st_q)
        S_STRAP: begin
          tmr_q <= 32'h0;
          // Strap pattern or an invalid application image selects the bootloader
          if ((!slp_s_q[1] && !din_s_q[1] && rts_s_q[1]) || !app_valid_in) begin
            st_q <= S_WAIT_CR;
            bl_active_out <= 1'b1;
          end else begin
            st_q <= S_APP;
          end
        end
        S_APP: st_q <= S_APP;
        S_WAIT_CR: if (rxv && rxd == CH_CR) begin
          st_q <= S_MENU;
          menu_q <= 3'h0;
        end
        S_MENU: if (!txb && !go_q) begin
          // Menu prompt goes out on the same fixed-rate UART
          go_q <= 1'b1;
          txd_q <= menu_chr(menu_q);
          menu_q <= menu_q + 3'h1;
          if (menu_q == 3'h4) begin
            st_q <= S_IDLE;
          end
        end
        S_IDLE: if (rxv && rxd == CH_ONE) begin
          st_q <= S_POLL;
          tmr_q <= 32'h0;
          exp_q <= 8'h01;
        end else if (rxv && rxd == X_SOH) begin
          err_code_out <= E_EARLY;
        end
        S_POLL: begin
          if (timed_out) begin
            st_q <= S_MENU;
            menu_q <= 3'h0;
          end else if (rxv) begin
            // XModem-CRC receive begins
            st_q <= (rxd == X_SOH) ? S_SEQ : S_POLL;
            if (rxd != X_SOH) begin
              err_code_out <= E_SOH;
            end
          end else if (!txb && !go_q && gap_q == 32'h0) begin
            go_q <= 1'b1;
            txd_q <= CH_C;
          end
        end
        S_SOH: if (rxv) begin
          if (rxd == X_SOH) begin
            st_q <= S_SEQ;
          end else if (rxd == X_EOT) begin
            reply_q <= X_ACK;
            st_q <= S_REPLY;
          end else begin
            err_code_out <= E_SOH;
            reply_q <= X_NAK;
            st_q <= S_REPLY;
          end
        end
        S_SEQ: if (rxv) begin
          seq_q <= rxd;
          st_q <= S_NSEQ;
        end
        S_NSEQ: if (rxv) begin
          idx_q <= 8'h00;
          crc_q <= 16'h0000;
          err_q <= (rxd != ~seq_q) ? E_SEQ : E_NONE;
          st_q <= S_DATA;
        end
        S_DATA: if (rxv) begin
          crc_q <= crc_nx;
          idx_q <= idx_q + 8'h01;
          if (idx_q == 8'(BLK_LEN - 1)) begin
            st_q <= S_CRCH;
          end
        end
        S_CRCH: if (rxv) begin
          crch_q <= rxd;
          st_q <= S_CRCL;
        end
        S_CRCL: if (rxv) begin
          st_q <= S_REPLY;
          reply_q <= X_NAK;
          if (err_q != E_NONE) begin
            err_code_out <= err_q;
          end else if (seq_q == exp_q - 8'h01) begin
            err_code_out <= E_DUP;
            reply_q <= X_ACK;
          end else if (seq_q != exp_q) begin
            err_code_out <= E_SEQ;
          end else if ({crch_q, rxd} != crc_q) begin
            err_code_out <= (crch_q != crc_q[15:8]) ? E_CRCH : E_CRCL;
            if (crch_q == crc_q[15:8] && rxd == crc_q[7:0]) begin
              err_code_out <= E_CSUM;
            end
          end else if (image_err_in != E_NONE) begin
            // Image, tag, buffer, region and flash faults from the store
            err_code_out <= image_err_in;
          end else begin
            reply_q <= X_ACK;
            exp_q <= exp_q + 8'h01;
          end
        end
        S_REPLY: if (!txb && !go_q) begin
          go_q <= 1'b1;
          txd_q <= reply_q;
          st_q <= (reply_q == X_ACK && err_code_out == E_NONE && exp_q == 8'h01) ? S_MENU : S_SOH;
        end
        default: st_q <= S_STRAP;
      endcase
      // A stall mid-frame marks the frame incomplete and asks for a resend
      if (gap_hit && (st_q == S_SEQ || st_q == S_NSEQ || st_q == S_DATA || st_q == S_CRCH || st_q == S_CRCL)) begin
        err_code_out <= E_INCOMP;
        reply_q <= X_NAK;
        st_q <= S_REPLY;
      end
      if (st_q == S_DATA && rxv) begin
        blk_valid_out <= 1'b1;
        blk_byte_out <= rxd;
      end
    end
  end
endmodule

// ### src/sblu_host.sv
// Upload host end: strap and break entry, prompt wait, start command, XModem-CRC send.
// Assumes the user supplies image bytes on demand in block order.
`timescale 1ns/1ns
module sblu_host
  import sblu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Link
  sblu_if.host link,
  // User side
  input wire logic start_in,
  input wire logic [7:0] nblocks_in,
  output logic byte_req_out,
  input wire logic [7:0] byte_in,
  output logic done_out,
  output logic fail_out
);
  typedef enum {H_IDLE, H_BREAK, H_CR, H_PROMPT, H_CMD, H_WAITC, H_SEND, H_ACK, H_EOT, H_FIN}
    sblu_hst_t;
  sblu_hst_t st_q;
  logic [1:0] dout_s_q;
  logic [15:0] cnt_q;
  logic [7:0] pos_q;
  logic [7:0] blk_q;
  logic [15:0] crc_q;
  logic [7:0] last_q;
  logic go_q;
  logic [7:0] txd_q;
  logic brk_q;
  logic din_q;
  logic rst_q;
  logic txb;
  logic txw;
  logic rxv;
  logic [7:0] rxd;
  logic [7:0] frame_byte;

  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ 16'h1021) : (r << 1);
    end
    return r;
  endfunction

  sblu_uart u_uart (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .rx_in(dout_s_q[1]),
    .tx_out(txw),
    .tx_go_in(go_q),
    .tx_data_in(txd_q),
    .tx_busy_out(txb),
    .rx_valid_out(rxv),
    .rx_data_out(rxd)
  );

  // Frame layout: SOH, seq, ~seq, 128 data, CRC high, CRC low
  assign frame_byte = (pos_q == 8'd0) ? X_SOH : (pos_q == 8'd1) ? blk_q : (pos_q == 8'd2) ? ~blk_q :
    (pos_q == 8'(BLK_LEN + 3)) ? crc_q[15:8] : (pos_q == 8'(BLK_LEN + 4)) ? crc_q[7:0] : byte_in;
  assign link.sleep_request_input = 1'b0;
  assign link.rts_n = 1'b1;
  assign link.din = din_q;
  assign link.dev_rst_n = rst_q;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dout_s_q <= 2'b11;
      din_q <= 1'b1;
    end else begin
      dout_s_q <= {dout_s_q[0], link.dout};
      din_q <= brk_q ? 1'b0 : txw;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= H_IDLE;
      cnt_q <= 16'h0000;
      pos_q <= 8'h00;
      blk_q <= 8'h01;
      crc_q <= 16'h0000;
      last_q <= 8'h00;
      go_q <= 1'b0;
      txd_q <= 8'h00;
      brk_q <= 1'b0;
      rst_q <= 1'b1;
      byte_req_out <= 1'b0;
      done_out <= 1'b0;
      fail_out <= 1'b0;
    end else begin
      go_q <= 1'b0;
      byte_req_out <= 1'b0;
      cnt_q <= cnt_q + 16'h0001;
      case (st_q)
        H_IDLE: if (start_in) begin
          // Whole image always restarts from block one
          // Break goes out first; reset follows once the line is already low
          st_q <= H_BREAK;
          brk_q <= 1'b1;
          cnt_q <= 16'h0000;
          blk_q <= 8'h01;
          done_out <= 1'b0;
          fail_out <= 1'b0;
        end
        H_BREAK: begin
          if (cnt_q == 16'h0002) begin
            rst_q <= 1'b0;
          end
          if (cnt_q == 16'(BREAK_CYC / 2)) begin
            rst_q <= 1'b1;
          end
          if (cnt_q == 16'(BREAK_CYC)) begin
            brk_q <= 1'b0;
            st_q <= H_CR;
            cnt_q <= 16'h0000;
          end
        end
        // Wait out a whole frame so the device receiver finishes the frame the break left open
        H_CR: if (cnt_q == 16'(BIT_CYC * 12)) begin
          go_q <= 1'b1;
          txd_q <= CH_CR;
          st_q <= H_PROMPT;
        end
        H_PROMPT: if (rxv) begin
          last_q <= rxd;
          if (last_q == CH_SP && rxd == CH_GT) begin
            st_q <= H_CMD;
          end
        end
        H_CMD: if (!txb && !go_q) begin
          go_q <= 1'b1;
          txd_q <= CH_ONE;
          st_q <= H_WAITC;
        end
        H_WAITC: if (rxv && rxd == CH_C) begin
          st_q <= H_SEND;
          pos_q <= 8'h00;
          crc_q <= 16'h0000;
        end
        H_SEND: if (!txb && !go_q) begin
          go_q <= 1'b1;
          txd_q <= frame_byte;
          pos_q <= pos_q + 8'h01;
          if (pos_q >= 8'd3 && pos_q < 8'(BLK_LEN + 3)) begin
            crc_q <= crc16(crc_q, byte_in);
            byte_req_out <= 1'b1;
          end
          if (pos_q == 8'(BLK_LEN + 4)) begin
            st_q <= H_ACK;
          end
        end
        H_ACK: if (rxv) begin
          pos_q <= 8'h00;
          crc_q <= 16'h0000;
          if (rxd == X_ACK) begin
            // Next block only after the previous one is acknowledged
            blk_q <= blk_q + 8'h01;
            st_q <= (blk_q == nblocks_in) ? H_EOT : H_SEND;
          end else if (rxd != X_NAK) begin
            fail_out <= 1'b1;
            st_q <= H_IDLE;
          end else begin
            // A NAK ends the upload as failed; the host returns to idle without resending the block
            fail_out <= 1'b1;
            st_q <= H_IDLE;
          end
        end
        H_EOT: if (!txb && !go_q) begin
          go_q <= 1'b1;
          txd_q <= X_EOT;
          st_q <= H_FIN;
        end
        H_FIN: if (rxv) begin
          done_out <= (rxd == X_ACK);
          fail_out <= (rxd != X_ACK);
          st_q <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end
endmodule

// ### src/sblu_if.sv
// Serial link between the upload host and the bootloader device.
// Assumes one shared clock; the testbench joins the two modports.
`timescale 1ns/1ns
interface sblu_if;
  logic din;
  logic dout;
  logic sleep_request_input;
  logic rts_n;
  logic dev_rst_n;
  modport host (output din, output sleep_request_input, output rts_n, output dev_rst_n, input dout);
  modport device (input din, input sleep_request_input, input rts_n, input dev_rst_n, output dout);
endinterface

// ### src/sblu_pkg.sv
// Shared constants for the serial bootloader upload link: UART timing, ASCII codes,
// XModem bytes, upload error codes and timeouts.
// Assumes a 10 MHz system clock on both ends.
// Notes on behaviour
// - Host holds sleep request low, RTS high
// - Host breaks data line, then resets device
// - Device enters bootloader on sampled strap levels
// - Host ends break, sends carriage return
// - Device sends menu at fixed baud
// - Flow control stays disabled on both ends
// - Host waits for prompt before commands
// - ASCII one starts firmware upload
// - XModem CRC upload, blocks in order
// - No transfer in timeout returns menu
// - Invalid image after reset enters bootloader
// - Host resends whole image after interruption
// - Codes 0x21 header, 0x22 checksum
// - Codes 0x23 CRC high, 0x24 CRC low
// - Codes 0x25 sequence, 0x27 duplicate
// - Code 0x26 incomplete frame
// - Codes 0x41, 0x42, 0x43 image checks
// - Codes 0x44, 0x45, 0x4c tag checks
// - Codes 0x46 odd bytes, 0x47 overflow
// - Codes 0x48, 0x49 protected regions
// - Codes 0x4a, 0x4b flash, 0x4d early data
package sblu_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned BAUD = 115200;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam int unsigned TIMEOUT_S = 60;
  localparam int unsigned TIMEOUT_CYC_DEF = TIMEOUT_S * CLK_HZ;
  localparam int unsigned GAP_MS = 10;
  localparam int unsigned GAP_CYC_DEF = GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned BREAK_CYC = BIT_CYC * 20;
  localparam int unsigned BLK_LEN = 128;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_B = 8'h42;
  localparam logic [7:0] CH_L = 8'h4c;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_GT = 8'h3e;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] X_SOH = 8'h01;
  localparam logic [7:0] X_EOT = 8'h04;
  localparam logic [7:0] X_ACK = 8'h06;
  localparam logic [7:0] X_NAK = 8'h15;
  localparam logic [7:0] E_SOH = 8'h21;
  localparam logic [7:0] E_CSUM = 8'h22;
  localparam logic [7:0] E_CRCH = 8'h23;
  localparam logic [7:0] E_CRCL = 8'h24;
  localparam logic [7:0] E_SEQ = 8'h25;
  localparam logic [7:0] E_INCOMP = 8'h26;
  localparam logic [7:0] E_DUP = 8'h27;
  localparam logic [7:0] E_NOHDR = 8'h41;
  localparam logic [7:0] E_HDRCRC = 8'h42;
  localparam logic [7:0] E_FILECRC = 8'h43;
  localparam logic [7:0] E_TAG = 8'h44;
  localparam logic [7:0] E_SIG = 8'h45;
  localparam logic [7:0] E_ODD = 8'h46;
  localparam logic [7:0] E_OVF = 8'h47;
  localparam logic [7:0] E_BLREG = 8'h48;
  localparam logic [7:0] E_EEREG = 8'h49;
  localparam logic [7:0] E_ERASE = 8'h4a;
  localparam logic [7:0] E_WRITE = 8'h4b;
  localparam logic [7:0] E_ENDCRC = 8'h4c;
  localparam logic [7:0] E_EARLY = 8'h4d;
  localparam logic [7:0] E_NONE = 8'h00;
endpackage

// ### src/sblu_uart.sv
// 8N1 UART transmitter and receiver at the fixed bootloader baud rate.
// Assumes rx_in is already synchronised to clk_sys_in.
`timescale 1ns/1ns
module sblu_uart
  import sblu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Serial lines
  input wire logic rx_in,
  output logic tx_out,
  // Transmit side
  input wire logic tx_go_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_busy_out,
  // Receive side
  output logic rx_valid_out,
  output logic [7:0] rx_data_out
);
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [9:0] tx_sh_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic tx_tick;
  logic rx_tick;
  assign tx_tick = (tx_cnt_q == 16'(BIT_CYC - 1));
  assign rx_tick = (rx_cnt_q == 16'(BIT_CYC - 1));
  assign tx_busy_out = (tx_bit_q != 4'h0);
  assign tx_out = tx_sh_q[0];

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_cnt_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 10'h3ff;
    end else if (tx_bit_q == 4'h0) begin
      tx_cnt_q <= 16'h0000;
      if (tx_go_in) begin
        tx_sh_q <= {1'b1, tx_data_in, 1'b0};
        tx_bit_q <= 4'ha;
      end
    end else if (tx_tick) begin
      tx_cnt_q <= 16'h0000;
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      tx_bit_q <= tx_bit_q - 4'h1;
    end else begin
      tx_cnt_q <= tx_cnt_q + 16'h0001;
    end
  end

  // Start bit sampled at its middle; a break just keeps restarting and fails the stop check
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
    end else begin
      rx_valid_out <= 1'b0;
      if (rx_bit_q == 4'h0) begin
        if (!rx_in) begin
          rx_bit_q <= 4'ha;
          rx_cnt_q <= 16'(BIT_CYC / 2);
        end
      end else if (rx_tick) begin
        rx_cnt_q <= 16'h0000;
        rx_bit_q <= rx_bit_q - 4'h1;
        if (rx_bit_q == 4'ha && rx_in) begin
          rx_bit_q <= 4'h0;
        end else if (rx_bit_q == 4'h1) begin
          rx_valid_out <= rx_in;
          rx_data_out <= rx_sh_q;
        end else if (rx_bit_q != 4'ha) begin
          rx_sh_q <= {rx_in, rx_sh_q[7:1]};
        end
      end else begin
        rx_cnt_q <= rx_cnt_q + 16'h0001;
      end
    end
  end
endmodule

// ### test/sblu_props.sv
// Concurrent checks on the serial link between the upload host and the device.
// Assumes one clock for both ends; instantiated by tb beside the joining interface.
`timescale 1ns/1ns
module sblu_props (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Link signals
  input wire logic din,
  input wire logic dout,
  input wire logic sleep_request_input,
  input wire logic rts_n,
  input wire logic dev_rst_n
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  property p_strap_at_reset;
    $fell(dev_rst_n) |-> !sleep_request_input && rts_n && !din;
  endproperty
  a_strap_at_reset: assert property (p_strap_at_reset) else $error("straps not set at reset");

  property p_strap_hold;
    !dev_rst_n |-> !sleep_request_input && rts_n;
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("straps moved in reset");

  property p_break_in_reset;
    !dev_rst_n |-> !din;
  endproperty
  a_break_in_reset: assert property (p_break_in_reset) else $error("break missing in reset");

  // Break must outlast the reset so the device samples a low data line
  property p_break_after;
    $rose(dev_rst_n) |-> !din [*8];
  endproperty
  a_break_after: assert property (p_break_after) else $error("break ended with reset");

  property p_quiet_in_reset;
    !dev_rst_n |-> dout;
  endproperty
  a_quiet_in_reset: assert property (p_quiet_in_reset) else $error("device talks in reset");

  property p_dout_low_bit;
    $fell(dout) |-> ##43 !dout;
  endproperty
  a_dout_low_bit: assert property (p_dout_low_bit) else $error("device low bit too short");

  property p_dout_high_bit;
    $rose(dout) |-> ##43 dout;
  endproperty
  a_dout_high_bit: assert property (p_dout_high_bit) else $error("device high bit too short");

  property p_din_low_bit;
    $fell(din) |-> ##43 !din;
  endproperty
  a_din_low_bit: assert property (p_din_low_bit) else $error("host low bit too short");

  c_reset_pulse: cover property ($rose(dev_rst_n));
  c_dev_byte: cover property ($fell(dout));
  c_host_byte: cover property ($rose(din) && dev_rst_n);
endmodule

// ### test/tb.sv
// Self-checking bench: host and device joined by one link, plus a second device
// driven by bench tasks that break the protocol on purpose.
`timescale 1ns/1ns
module tb;
  import sblu_pkg::*;
  localparam logic [7:0] MENU [5] = '{CH_CR, CH_B, CH_L, CH_SP, CH_GT};
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic start_in = 1'b0;
  localparam int unsigned SIM_TMO = 4000;
  logic app1 = 1'b1;
  logic app2 = 1'b1;
  logic [7:0] img_err2 = 8'h00;
  logic [7:0] nblocks_in = 8'h01;
  logic [7:0] blk [0:127];
  logic [7:0] bi = 8'h00;
  int bo = 0;
  int cyc = 0;
  int fails = 0;
  int total_checks = 0;
  wire logic byte_req, done, fail, act, bv, act2;
  wire logic [7:0] bb, err, err2;
  sblu_if lk ();
  sblu_if lk2 ();

  sblu_host sblu_host_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .link(lk.host), .start_in(start_in),
    .nblocks_in(nblocks_in), .byte_req_out(byte_req), .byte_in(blk[bi[6:0]]), .done_out(done), .fail_out(fail));
  sblu_device #(.TIMEOUT_CYC(SIM_TMO), .GAP_CYC(5000)) sblu_device_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .link(lk.device), .app_valid_in(app1), .image_err_in(8'h00), .bl_active_out(act), .blk_valid_out(bv),
    .blk_byte_out(bb), .err_code_out(err));
  sblu_device #(.TIMEOUT_CYC(SIM_TMO), .GAP_CYC(5000)) sblu_device_i2 (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .link(lk2.device), .app_valid_in(app2), .image_err_in(img_err2), .bl_active_out(act2), .blk_valid_out(),
    .blk_byte_out(), .err_code_out(err2));
  sblu_props sblu_props_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .din(lk.din), .dout(lk.dout),
    .sleep_request_input(lk.sleep_request_input), .rts_n(lk.rts_n), .dev_rst_n(lk.dev_rst_n));

  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (byte_req) bi <= bi + 8'h01;
    if (bv) begin
      check(bb, blk[bo[6:0]]);
      bo <= bo + 1;
    end
  end

  // Leading idle bit time stands in for the stop bit so replies are never missed
  task automatic tx(input logic [7:0] b);
    logic [8:0] f;
    f = {b, 1'b0};
    repeat (BIT_CYC) @(negedge clk_sys_in);
    for (int i = 0; i < 9; i++) begin
      lk2.din = f[i];
      repeat (BIT_CYC) @(negedge clk_sys_in);
    end
    lk2.din = 1'b1;
  endtask

  task automatic rx(output logic [7:0] b);
    int n;
    n = 0;
    b = 8'h00;
    while (lk2.dout !== 1'b0 && n < 40000) begin
      @(posedge clk_sys_in);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge clk_sys_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_sys_in);
      b[i] = lk2.dout;
    end
    repeat (BIT_CYC) @(posedge clk_sys_in);
  endtask

  task automatic wait_err(input logic [7:0] exp);
    int n;
    n = 0;
    while (err2 !== exp && n < 8000) begin
      @(negedge clk_sys_in);
      n++;
    end
  endtask

  task automatic pulse_reset();
    @(negedge clk_sys_in);
    lk2.dev_rst_n = 1'b0;
    repeat (10) @(negedge clk_sys_in);
    lk2.dev_rst_n = 1'b1;
  endtask

  task automatic host_test();
    int n;
    @(negedge clk_sys_in);
    start_in = 1'b1;
    @(negedge clk_sys_in);
    start_in = 1'b0;
    n = 0;
    while (!(done === 1'b1 || fail === 1'b1) && n < 250000) begin
      @(negedge clk_sys_in);
      n++;
    end
    check(done, 1'b1);
    check(fail, 1'b0);
    check(8'(bo), 8'h80);
    check(act, 1'b1);
    check(err, E_NONE);
    $display("host upload test done");
  endtask

  task automatic dev2_test();
    logic [7:0] b;
    logic [7:0] seq;
    int t0;
    int k;
    app2 = 1'b0;
    pulse_reset();
    repeat (10) @(negedge clk_sys_in);
    check(act2, 1'b1);
    app2 = 1'b1;
    pulse_reset();
    repeat (10) @(negedge clk_sys_in);
    check(act2, 1'b0);
    lk2.sleep_request_input = 1'b0;
    lk2.rts_n = 1'b1;
    lk2.din = 1'b0;
    pulse_reset();
    repeat (200) @(negedge clk_sys_in);
    lk2.din = 1'b1;
    // Let the receiver finish the frame the break opened before the real CR
    repeat (BIT_CYC * 12) @(negedge clk_sys_in);
    tx(CH_CR);
    for (int i = 0; i < 5; i++) begin
      rx(b);
      check(b, MENU[i]);
    end
    check(act2, 1'b1);
    tx(CH_ONE);
    t0 = cyc;
    rx(b);
    check(b, CH_C);
    k = 0;
    while (b !== CH_GT && k < 40) begin
      rx(b);
      k++;
    end
    check(b, CH_GT);
    check(8'(cyc - t0 >= SIM_TMO), 8'h01);
    check(8'(cyc - t0 < SIM_TMO + 6000), 8'h01);
    tx(X_SOH);
    wait_err(E_EARLY);
    check(err2, E_EARLY);
    tx(CH_ONE);
    tx(8'h5a);
    wait_err(E_SOH);
    check(err2, E_SOH);
    seq = 8'($urandom);
    // A bad complement is only reported once the whole frame is in; it outranks an image fault
    img_err2 = E_NOHDR + 8'($urandom % 13);
    tx(X_SOH);
    tx(seq);
    tx(seq);
    repeat (BLK_LEN + 2) tx(8'($urandom));
    wait_err(E_SEQ);
    img_err2 = 8'h00;
    check(err2, E_SEQ);
    tx(X_SOH);
    tx(8'h01);
    tx(8'hfe);
    wait_err(E_INCOMP);
    check(err2, E_INCOMP);
    $display("fault device test done");
  endtask

  initial begin
    lk2.din = 1'b1;
    lk2.sleep_request_input = 1'b1;
    lk2.rts_n = 1'b0;
    lk2.dev_rst_n = 1'b1;
    void'($urandom(46));
    foreach (blk[i]) blk[i] = 8'($urandom);
    repeat (6) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    fork
      host_test();
      dev2_test();
    join
    conclude();
  end

  // The fault device also sends a full frame, about 140000 cycles in all; allow about three times that
  initial begin
    repeat (400000) @(posedge clk_sys_in);
    fails++;
    conclude();
  end
endmodule
